/* File: core_seq_model.sv */
`timescale 1ns/1ps
module core_seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic [3:0] ack_gap_i,
  input wire logic ret_req_i,
  // Handler side
  input wire logic call_req_i,
  input wire logic [15:0] call_vector_i,
  output logic instr_done_o,
  output logic ret_done_o,
  output logic call_ack_o,
  // Observation
  output logic [15:0] last_vec_o,
  output logic [7:0] n_calls_o
);
  // ==========================================================
  // Instruction slots every fourth cycle, none while a call waits
  logic [1:0] step_ff;
  logic [3:0] wait_ff;
  logic ret_pend_ff;
  wire slot = (step_ff == 2'h3) && !call_req_i;
  // A slow core leaves the call standing for ack_gap_i cycles
  wire ack_now = call_req_i && !call_ack_o && (wait_ff == ack_gap_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_ff <= 2'h0;
      wait_ff <= 4'h0;
      ret_pend_ff <= 1'b0;
      instr_done_o <= 1'b0;
      ret_done_o <= 1'b0;
      call_ack_o <= 1'b0;
      last_vec_o <= 16'h0000;
      n_calls_o <= 8'h00;
    end else begin
      step_ff <= step_ff + 2'h1;
      instr_done_o <= slot && !ret_pend_ff;
      ret_done_o <= slot && ret_pend_ff;
      ret_pend_ff <= ret_req_i || (ret_pend_ff && !slot);
      wait_ff <= (call_req_i && !ack_now) ? wait_ff + 4'h1 : 4'h0;
      call_ack_o <= ack_now;
      if (call_ack_o) begin
        last_vec_o <= call_vector_i;
        n_calls_o <= n_calls_o + 8'h01;
      end
    end
  end
endmodule

/* File: flag_bus_if.sv */
`timescale 1ns/1ps
interface flag_bus_if;
  logic [19:0] flags;
  logic sw_wr;
  logic [19:0] sw_data;
  logic [19:0] hw_clr;
  logic [1:0] edge_mode;
  modport bank (input sw_wr, input sw_data, input hw_clr, input edge_mode, output flags);
  modport ctrl (output sw_wr, output sw_data, output hw_clr, output edge_mode, input flags);
endinterface

/* File: pend_flag_bank.sv */
`timescale 1ns/1ps
module pend_flag_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sources
  input wire logic [19:0] periph_event_i,
  input wire logic [1:0] ext_int_n_i,
  // Control side
  flag_bus_if.bank fb
);

  // ==========================================================
  // External pin edge detect
  logic [1:0] pin_prev_ff;
  logic [19:0] flags_ff;
  logic [19:0] set_w;
  logic [19:0] lvl_w;
  logic [19:0] pin_act_w;
  logic [1:0] fall_w;

  assign fall_w = pin_prev_ff & ~ext_int_n_i;
  // Edge sources latch a falling edge, level sources show the pin
  assign set_w = periph_event_i & ~vih_pkg::EXT_MASK
                 | {17'h00000, fall_w[1] & fb.edge_mode[1], 1'b0, fall_w[0] & fb.edge_mode[0]};
  assign lvl_w = {17'h00000, ~fb.edge_mode[1], 1'b0, ~fb.edge_mode[0]};
  assign pin_act_w = {17'h00000, ~ext_int_n_i[1], 1'b0, ~ext_int_n_i[0]};
  assign fb.flags = flags_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_ff <= 2'h3;
    end else begin
      pin_prev_ff <= ext_int_n_i;
    end
  end

  // ==========================================================
  // Per-source flag; a set in the clearing cycle wins
  for (genvar k = 0; k < 20; k++) begin : g_flag
    logic nxt_flag;
    assign nxt_flag = lvl_w[k] ? pin_act_w[k] :
                      set_w[k] ? 1'b1 :
                      fb.sw_wr ? fb.sw_data[k] :
                      flags_ff[k] & ~fb.hw_clr[k];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags_ff[k] <= 1'b0;
      end else begin
        flags_ff[k] <= nxt_flag;
      end
    end
  end

endmodule

/* File: prio_pick.sv */
`timescale 1ns/1ps
module prio_pick (
  // Requests
  input wire logic [19:0] req_i,
  input wire logic [19:0] prio_i,
  input wire logic allow_hi_i,
  input wire logic allow_lo_i,
  // Winner
  output logic valid_o,
  output logic high_o,
  output logic [4:0] idx_o
);

  // Lowest set index wins within a level
  function automatic logic [4:0] first_set(input logic [19:0] v);
    first_set = 5'h00;
    for (int i = 19; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  logic [19:0] hi_w;
  logic [19:0] lo_w;

  assign hi_w = req_i & prio_i & {20{allow_hi_i}};
  assign lo_w = req_i & ~prio_i & {20{allow_lo_i}};
  assign high_o = |hi_w;
  assign valid_o = high_o | (|lo_w);
  assign idx_o = high_o ? first_set(hi_w) : first_set(lo_w);

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic clk_i;
  logic rst_i;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [19:0] periph_event;
  logic [1:0] ext_int_n;
  logic [3:0] ack_gap;
  logic ret_req;
  logic instr_done;
  logic ret_done;
  logic call_ack;
  logic call_req;
  logic [15:0] call_vector;
  logic [15:0] last_vec;
  logic [1:0] in_service;
  logic [7:0] n_calls;
  logic [7:0] calls_seen;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  vectored_interrupt_handler dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .periph_event_i(periph_event),
    .ext_int_n_i(ext_int_n), .instr_done_i(instr_done), .ret_done_i(ret_done),
    .call_ack_i(call_ack), .call_req_o(call_req), .call_vector_o(call_vector),
    .in_service_o(in_service));

  core_seq_model core_u (.clk_i(clk_i), .rst_i(rst_i), .ack_gap_i(ack_gap),
    .ret_req_i(ret_req), .call_req_i(call_req), .call_vector_i(call_vector),
    .instr_done_o(instr_done), .ret_done_o(ret_done), .call_ack_o(call_ack),
    .last_vec_o(last_vec), .n_calls_o(n_calls));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ==========================================================
  // Tasks
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request stands until the edge that samples waitrequest low
  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    av_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    av_xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_call(input logic [15:0] exp);
    @(posedge clk_i);
    while (n_calls === calls_seen) @(posedge clk_i);
    calls_seen = calls_seen + 8'h01;
    chk("vector", {16'h0, exp}, {16'h0, last_vec});
  endtask

  task automatic no_call;
    repeat (30) @(posedge clk_i);
    chk("calls", {24'h0, calls_seen}, {24'h0, n_calls});
  endtask

  task automatic chk_svc(input logic [1:0] exp);
    chk("in_service", {30'h0, exp}, {30'h0, in_service});
  endtask

  task automatic do_ret;
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    while (ret_done !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
  endtask

  task automatic pulse_ev(input int k);
    periph_event <= 20'h1 << k;
    @(posedge clk_i);
    periph_event <= 20'h0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    periph_event = 20'h0;
    ext_int_n = 2'h3;
    ack_gap = 4'h0;
    ret_req = 1'b0;
    calls_seen = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);

    for (int i = 0; i < 7; i++) rd_chk("reset", 8'(i * 4), 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(vih_pkg::OFF_MAIN_EN, 32'hff);
    rd_chk("main_en", vih_pkg::OFF_MAIN_EN, 32'hbf);
    wr(vih_pkg::OFF_MAIN_EN, 32'h0);
    $display("test registers done");

    pulse_ev(5);
    rd_chk("pending", vih_pkg::OFF_PEND, 32'h20);
    no_call();
    wr(vih_pkg::OFF_MAIN_EN, 32'h20);
    no_call();
    wr(vih_pkg::OFF_MAIN_EN, 32'ha0);
    wait_call(16'h002b);
    chk_svc(2'b01);
    do_ret();
    wait_call(16'h002b);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    chk_svc(2'b00);
    // Each bus access spans two cycles, like a multi-byte instruction
    wr(vih_pkg::OFF_MAIN_EN, 32'h20);
    wr(vih_pkg::OFF_PEND, 32'h20);
    no_call();
    wr(vih_pkg::OFF_MAIN_EN, 32'ha0);
    wait_call(16'h002b);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    $display("test gating done");

    wr(vih_pkg::OFF_MAIN_EN, 32'hb0);
    wr(vih_pkg::OFF_PEND, 32'h30);
    wait_call(16'h0023);
    wr(vih_pkg::OFF_PEND, 32'h20);
    do_ret();
    wait_call(16'h002b);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    wr(vih_pkg::OFF_PRIO, 32'h20);
    wr(vih_pkg::OFF_PEND, 32'h30);
    wait_call(16'h002b);
    chk_svc(2'b10);
    no_call();
    wr(vih_pkg::OFF_PEND, 32'h10);
    do_ret();
    wait_call(16'h0023);
    pulse_ev(5);
    wait_call(16'h002b);
    chk_svc(2'b11);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    chk_svc(2'b01);
    do_ret();
    chk_svc(2'b00);
    $display("test priority done");

    wr(vih_pkg::OFF_PRIO, 32'h0);
    wr(vih_pkg::OFF_MAIN_EN, 32'h82);
    wr(vih_pkg::OFF_PEND, 32'h02);
    wait_call(16'h000b);
    rd_chk("hw_clear", vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    ack_gap <= 4'h3;
    wr(vih_pkg::OFF_MAIN_EN, 32'h80);
    wr(vih_pkg::OFF_EXT_EN_ONE, 32'h40);
    pulse_ev(12);
    wait_call(16'h0063);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    wr(vih_pkg::OFF_EXT_EN_TWO, 32'h40);
    pulse_ev(19);
    wait_call(16'h00a3);
    wr(vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    rd_chk("status", vih_pkg::OFF_STAT, 32'h1300);
    $display("test sources done");

    wr(vih_pkg::OFF_MAIN_EN, 32'h0);
    ext_int_n <= 2'b10;
    repeat (3) @(posedge clk_i);
    rd_chk("level_on", vih_pkg::OFF_PEND, 32'h1);
    ext_int_n <= 2'b11;
    repeat (3) @(posedge clk_i);
    rd_chk("level_off", vih_pkg::OFF_PEND, 32'h0);
    wr(vih_pkg::OFF_CFG, 32'h1);
    ext_int_n <= 2'b10;
    repeat (2) @(posedge clk_i);
    ext_int_n <= 2'b11;
    repeat (3) @(posedge clk_i);
    rd_chk("edge_set", vih_pkg::OFF_PEND, 32'h1);
    // Second pin: level first, then edge mode
    ext_int_n <= 2'b01;
    repeat (3) @(posedge clk_i);
    rd_chk("level_two", vih_pkg::OFF_PEND, 32'h5);
    ext_int_n <= 2'b11;
    wr(vih_pkg::OFF_CFG, 32'h3);
    ext_int_n <= 2'b01;
    repeat (2) @(posedge clk_i);
    ext_int_n <= 2'b11;
    repeat (3) @(posedge clk_i);
    rd_chk("edge_two", vih_pkg::OFF_PEND, 32'h5);
    wr(vih_pkg::OFF_MAIN_EN, 32'h85);
    wait_call(16'h0003);
    do_ret();
    wait_call(16'h0013);
    rd_chk("edge_clear", vih_pkg::OFF_PEND, 32'h0);
    do_ret();
    $display("test external done");
    final_report();
  end
endmodule

/* File: vectored_interrupt_handler.sv */
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module vectored_interrupt_handler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt sources
  input wire logic [19:0] periph_event_i,
  input wire logic [1:0] ext_int_n_i,
  // Core sequencer
  input wire logic instr_done_i,
  input wire logic ret_done_i,
  input wire logic call_ack_i,
  output logic call_req_o,
  output logic [15:0] call_vector_o,
  output logic [1:0] in_service_o
);

  // ==========================================================
  // Registers
  logic [7:0] main_int_enable_reg_ff;
  logic [6:0] extended_enable_reg_one_ff;
  logic [6:0] extended_enable_reg_two_ff;
  logic [19:0] priority_select_reg_ff;
  logic [1:0] cfg_ff;
  logic [31:0] rdata_ff;
  logic wait_ff;
  logic [19:0] req_ff;
  logic act_hi_ff;
  logic act_lo_ff;
  logic call_req_ff;
  logic [15:0] call_vector_ff;
  logic [4:0] call_src_ff;
  logic call_hi_ff;
  vih_pkg::call_state_e state_ff;

  flag_bus_if fb ();

  pend_flag_bank u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .periph_event_i(periph_event_i),
    .ext_int_n_i(ext_int_n_i),
    .fb(fb.bank)
  );

  // ==========================================================
  // Bus decode
  logic req_seen_w;
  logic wr_w;
  logic hit_main_w;
  logic hit_one_w;
  logic hit_two_w;
  logic hit_prio_w;
  logic hit_pend_w;
  logic hit_cfg_w;
  logic hit_stat_w;
  logic [31:0] rd_mux_w;
  logic [31:0] stat_w;

  // First request cycle latches read data; the second ends the access
  assign req_seen_w = (avs_read_i | avs_write_i) & wait_ff;
  assign wr_w = avs_write_i & ~wait_ff;
  assign hit_main_w = avs_address_i == vih_pkg::OFF_MAIN_EN;
  assign hit_one_w = avs_address_i == vih_pkg::OFF_EXT_EN_ONE;
  assign hit_two_w = avs_address_i == vih_pkg::OFF_EXT_EN_TWO;
  assign hit_prio_w = avs_address_i == vih_pkg::OFF_PRIO;
  assign hit_pend_w = avs_address_i == vih_pkg::OFF_PEND;
  assign hit_cfg_w = avs_address_i == vih_pkg::OFF_CFG;
  assign hit_stat_w = avs_address_i == vih_pkg::OFF_STAT;
  assign stat_w = {19'h00000, call_src_ff, 5'h00, call_req_ff, act_lo_ff, act_hi_ff};

  always_comb begin
    if (hit_main_w) begin
      rd_mux_w = {24'h000000, main_int_enable_reg_ff};
    end else if (hit_one_w) begin
      rd_mux_w = {25'h0000000, extended_enable_reg_one_ff};
    end else if (hit_two_w) begin
      rd_mux_w = {25'h0000000, extended_enable_reg_two_ff};
    end else if (hit_prio_w) begin
      rd_mux_w = {12'h000, priority_select_reg_ff};
    end else if (hit_pend_w) begin
      rd_mux_w = {12'h000, fb.flags};
    end else if (hit_cfg_w) begin
      rd_mux_w = {30'h00000000, cfg_ff};
    end else if (hit_stat_w) begin
      rd_mux_w = stat_w;
    end else begin
      rd_mux_w = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= ~req_seen_w;
      if (req_seen_w) begin
        rdata_ff <= rd_mux_w;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_int_enable_reg_ff <= vih_pkg::MAIN_EN_RST;
      extended_enable_reg_one_ff <= vih_pkg::EXT_EN_RST;
      extended_enable_reg_two_ff <= vih_pkg::EXT_EN_RST;
      priority_select_reg_ff <= vih_pkg::PRIO_RST;
      cfg_ff <= vih_pkg::CFG_RST;
    end else if (wr_w) begin
      if (hit_main_w) begin
        main_int_enable_reg_ff <= avs_writedata_i[7:0] & 8'hbf;
      end
      if (hit_one_w) begin
        extended_enable_reg_one_ff <= avs_writedata_i[6:0];
      end
      if (hit_two_w) begin
        extended_enable_reg_two_ff <= avs_writedata_i[6:0];
      end
      if (hit_prio_w) begin
        priority_select_reg_ff <= avs_writedata_i[19:0];
      end
      if (hit_cfg_w) begin
        cfg_ff <= avs_writedata_i[1:0];
      end
    end
  end

  assign fb.sw_wr = wr_w & hit_pend_w;
  assign fb.sw_data = avs_writedata_i[19:0];
  assign fb.edge_mode = cfg_ff;

  // ==========================================================
  // Request gating and arbitration
  logic glb_w;
  logic [19:0] en_w;
  logic [19:0] req_raw_w;
  logic pick_valid_w;
  logic pick_hi_w;
  logic [4:0] pick_idx_w;
  logic take_w;
  logic ack_w;
  logic [19:0] src_onehot_w;

  assign glb_w = main_int_enable_reg_ff[vih_pkg::GLB_BIT];
  assign en_w = {extended_enable_reg_two_ff, extended_enable_reg_one_ff,
                 main_int_enable_reg_ff[5:0]};
  assign req_raw_w = fb.flags & en_w & {20{glb_w}};

  // Request is registered, so a clear of the global enable still lets a request
  // already posted through at the end of a one-cycle instruction, not a longer one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ff <= 20'h00000;
    end else begin
      req_ff <= req_raw_w;
    end
  end

  prio_pick u_pick (
    .req_i(req_ff),
    .prio_i(priority_select_reg_ff),
    .allow_hi_i(~act_hi_ff),
    .allow_lo_i(~act_hi_ff & ~act_lo_ff),
    .valid_o(pick_valid_w),
    .high_o(pick_hi_w),
    .idx_o(pick_idx_w)
  );

  // The end of the return itself is never a take point
  assign take_w = state_ff == vih_pkg::ST_IDLE & instr_done_i & ~ret_done_i
                  & pick_valid_w;
  assign ack_w = state_ff == vih_pkg::ST_CALL & call_ack_i;
  assign src_onehot_w = 20'h00001 << call_src_ff;
  assign fb.hw_clr = ack_w ? src_onehot_w & vih_pkg::HW_CLR_MASK : 20'h00000;

  // ==========================================================
  // Call sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= vih_pkg::ST_IDLE;
      call_req_ff <= 1'b0;
      call_vector_ff <= 16'h0000;
      call_src_ff <= 5'h00;
      call_hi_ff <= 1'b0;
    end else begin
      case (state_ff)
        vih_pkg::ST_IDLE: begin
          if (take_w) begin
            state_ff <= vih_pkg::ST_CALL;
            call_req_ff <= 1'b1;
            call_vector_ff <= vih_pkg::vector_of(pick_idx_w);
            call_src_ff <= pick_idx_w;
            call_hi_ff <= pick_hi_w;
          end
        end
        vih_pkg::ST_CALL: begin
          if (call_ack_i) begin
            state_ff <= vih_pkg::ST_IDLE;
            call_req_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= vih_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Service levels: entry marks a level, the return releases the innermost one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_hi_ff <= 1'b0;
      act_lo_ff <= 1'b0;
    end else if (ack_w) begin
      act_hi_ff <= act_hi_ff | call_hi_ff;
      act_lo_ff <= act_lo_ff | ~call_hi_ff;
    end else if (ret_done_i) begin
      if (act_hi_ff) begin
        act_hi_ff <= 1'b0;
      end else begin
        act_lo_ff <= 1'b0;
      end
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign call_req_o = call_req_ff;
  assign call_vector_o = call_vector_ff;
  assign in_service_o = {act_hi_ff, act_lo_ff};

  // ==========================================================
  // Assertions
  glob_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !glb_w |=> req_ff == 20'h00000) else $error("request passed with global off");
  en_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (req_ff & ~$past(en_w)) == 20'h00000) else $error("disabled source requested");
  evt_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |(periph_event_i & ~vih_pkg::EXT_MASK) |=>
    (fb.flags & $past(periph_event_i & ~vih_pkg::EXT_MASK))
    == $past(periph_event_i & ~vih_pkg::EXT_MASK)) else $error("event did not set flag");
  take_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take_w |=> call_req_o && call_vector_o == vih_pkg::vector_of($past(pick_idx_w)))
    else $error("wrong vector after take");
  no_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == vih_pkg::ST_IDLE && req_ff == 20'h00000 |=> !call_req_o)
    else $error("call without request");
  hi_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    act_hi_ff |-> !take_w && !call_req_o) else $error("high routine preempted");
  ret_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ret_done_i |=> !call_req_o) else $error("re-entry without next instruction");
  lvl_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take_w && !pick_hi_w |-> (req_ff & priority_select_reg_ff) == 20'h00000 || act_hi_ff)
    else $error("low served before high");
  // Only checked while no set or software write races the hardware clear
  hw_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_w && vih_pkg::HW_CLR_MASK[call_src_ff] && !(call_src_ff == 5'h00 && !cfg_ff[0])
    && !(call_src_ff == 5'h02 && !cfg_ff[1]) && !periph_event_i[call_src_ff]
    && ext_int_n_i == 2'h3 && !fb.sw_wr |=> !fb.flags[$past(call_src_ff)])
    else $error("flag not cleared on vectoring");
  bus_ans_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_seen_w |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bad wait timing");

  take_c: cover property (@(posedge clk_i) disable iff (rst_i) take_w);
  preempt_c: cover property (@(posedge clk_i) disable iff (rst_i) take_w && act_lo_ff);
  reenter_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ret_done_i ##[1:20] take_w);
  sw_set_c: cover property (@(posedge clk_i) disable iff (rst_i) fb.sw_wr && |fb.sw_data);
  clr_race_c: cover property (@(posedge clk_i) disable iff (rst_i) take_w && !glb_w);

endmodule

/* File: vih_pkg.sv */
package vih_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_SRC = 20;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned VEC_W = 16;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_MAIN_EN = 8'h00;
  localparam logic [7:0] OFF_EXT_EN_ONE = 8'h04;
  localparam logic [7:0] OFF_EXT_EN_TWO = 8'h08;
  localparam logic [7:0] OFF_PRIO = 8'h0c;
  localparam logic [7:0] OFF_PEND = 8'h10;
  localparam logic [7:0] OFF_CFG = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;

  // ==========================================================
  // Field layout
  localparam int unsigned GLB_BIT = 7;
  localparam int unsigned MAIN_SRC_N = 6;
  localparam int unsigned EXT_ONE_N = 7;
  localparam int unsigned EXT_TWO_N = 7;
  localparam int unsigned CFG_W = 2;
  localparam int unsigned STAT_SRC_LSB = 8;
  localparam int unsigned EXT0_SRC = 0;
  localparam int unsigned EXT1_SRC = 2;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] MAIN_EN_RST = 8'h00;
  localparam logic [6:0] EXT_EN_RST = 7'h00;
  localparam logic [19:0] PRIO_RST = 20'h00000;
  localparam logic [19:0] PEND_RST = 20'h00000;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [19:0] HW_CLR_MASK = 20'h4000f;
  localparam logic [19:0] EXT_MASK = 20'h00005;

  typedef enum logic {ST_IDLE, ST_CALL} call_state_e;

  // Fixed entry address of each source
  function automatic logic [15:0] vector_of(input logic [4:0] idx);
    case (idx)
      5'h00: vector_of = 16'h0003;
      5'h01: vector_of = 16'h000b;
      5'h02: vector_of = 16'h0013;
      5'h03: vector_of = 16'h001b;
      5'h04: vector_of = 16'h0023;
      5'h05: vector_of = 16'h002b;
      5'h06: vector_of = 16'h0033;
      5'h07: vector_of = 16'h003b;
      5'h08: vector_of = 16'h0043;
      5'h09: vector_of = 16'h004b;
      5'h0a: vector_of = 16'h0053;
      5'h0b: vector_of = 16'h005b;
      5'h0c: vector_of = 16'h0063;
      5'h0d: vector_of = 16'h0073;
      5'h0e: vector_of = 16'h007b;
      5'h0f: vector_of = 16'h0083;
      5'h10: vector_of = 16'h0093;
      5'h11: vector_of = 16'h008b;
      5'h12: vector_of = 16'h009b;
      default: vector_of = 16'h00a3;
    endcase
  endfunction

endpackage
